// ==== rbfpc_params.svh ====
// Constants for the receive-buffer-full pin control block
`ifndef RBFPC_PARAMS_SVH
`define RBFPC_PARAMS_SVH

// ----------------------------------------
// Register offsets (8-bit address)
// ----------------------------------------
`define RBFPC_ADDR_PIN_CTRL 8'h0C
`define RBFPC_ADDR_IRQ_STAT 8'h2C
`define RBFPC_ADDR_IRQ_MASK 8'h2B

// ----------------------------------------
// Field positions of the pin control register
// ----------------------------------------
`define RBFPC_BIT_MODE0  0
`define RBFPC_BIT_MODE1  1
`define RBFPC_BIT_EN0    2
`define RBFPC_BIT_EN1    3
`define RBFPC_BIT_LVL0   4
`define RBFPC_BIT_LVL1   5
`define RBFPC_CTRL_WMASK 8'h3F

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RBFPC_CTRL_RST 8'h00
`define RBFPC_STAT_RST 2'h0
`define RBFPC_MASK_RST 2'h0
`define RBFPC_RDATA_RST 8'h00
// Pin comes out of reset floating, idle level high
`define RBFPC_PIN_IDLE 1'b1
`define RBFPC_PIN_OFF  1'b0

`endif

// ==== rbfpc_pkg.sv ====
// Types shared by the receive-buffer-full pin control block
package rbfpc_pkg;

  // ----------------------------------------
  // Register bus request
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rbfpc_bus_t;

  // ----------------------------------------
  // Per-pin configuration
  // ----------------------------------------
  typedef struct packed {
    logic en;
    logic irq_mode;
    logic level;
  } rbfpc_pin_cfg_t;

  // Pin function as decoded from its configuration
  typedef enum logic [1:0] {
    RBFPC_FN_HIZ,
    RBFPC_FN_IRQ,
    RBFPC_FN_GPO
  } rbfpc_fn_t;

endpackage

// ==== rbfpc_pin.sv ====
// One buffer-full pin driver: tri-state, interrupt or digital output
`timescale 1ns/100ps
`include "rbfpc_params.svh"

module rbfpc_pin (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     nrst,
  // Configuration and state
  input  wire rbfpc_pkg::rbfpc_pin_cfg_t cfg,
  input  wire logic                     rx_flag,
  // Pin
  output logic                          pin_o,
  output logic                          pin_oe
);

  rbfpc_pkg::rbfpc_fn_t fn;
  logic                 next_pin_o;
  logic                 next_pin_oe;

  // Function decode and next pin drive
  always_comb begin
    if (!cfg.en) begin
      fn = rbfpc_pkg::RBFPC_FN_HIZ;
    end else if (cfg.irq_mode) begin
      fn = rbfpc_pkg::RBFPC_FN_IRQ;
    end else begin
      fn = rbfpc_pkg::RBFPC_FN_GPO;
    end
    next_pin_o  = 1'b1;
    next_pin_oe = 1'b0;
    case (fn)
      // Active low while the receive flag stands
      rbfpc_pkg::RBFPC_FN_IRQ: begin
        next_pin_o  = ~rx_flag;
        next_pin_oe = 1'b1;
      end
      rbfpc_pkg::RBFPC_FN_GPO: begin
        next_pin_o  = cfg.level;
        next_pin_oe = 1'b1;
      end
      rbfpc_pkg::RBFPC_FN_HIZ: begin
        next_pin_o  = 1'b1;
        next_pin_oe = 1'b0;
      end
      default: begin
        next_pin_o  = 1'b1;
        next_pin_oe = 1'b0;
      end
    endcase
  end

  // Registered pin drive, floating out of reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_o  <= `RBFPC_PIN_IDLE;
      pin_oe <= `RBFPC_PIN_OFF;
    end else begin
      pin_o  <= next_pin_o;
      pin_oe <= next_pin_oe;
    end
  end

endmodule

// ==== rbfpc_top.sv ====
// Receive-buffer-full pin control: register, interrupt status and two pin drivers
`timescale 1ns/100ps
`include "rbfpc_params.svh"

module rbfpc_top (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // Register bus
  input  wire logic [7:0]           addr,
  input  wire logic [7:0]           wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic      [7:0]           rdata,
  // Receive events from the buffer logic
  input  wire logic                 rx0_loaded,
  input  wire logic                 rx1_loaded,
  // Buffer-full pins
  output logic                      rx_full_pin_zero_o,
  output logic                      rx_full_pin_zero_oe,
  output logic                      rx_full_pin_one_o,
  output logic                      rx_full_pin_one_oe,
  // Interrupt
  output logic                      irq
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  rbfpc_pkg::rbfpc_bus_t     bus;
  rbfpc_pkg::rbfpc_pin_cfg_t cfg0;
  rbfpc_pkg::rbfpc_pin_cfg_t cfg1;
  logic [7:0]                buffer_full_pin_control;
  logic [7:0]                next_buffer_full_pin_control;
  logic [1:0]                rx_status;
  logic [1:0]                next_rx_status;
  logic [1:0]                rx_mask;
  logic [1:0]                next_rx_mask;
  logic [7:0]                next_rdata;

  // Bus fields gathered in one carrier
  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // Address match helper, used by write and read decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  // State bit as read back: zero in interrupt mode
  function automatic logic lvl_rd(input logic lvl, input logic mode);
    lvl_rd = lvl & ~mode;
  endfunction

  // Next register values
  always_comb begin
    next_buffer_full_pin_control = buffer_full_pin_control;
    next_rx_mask                 = rx_mask;
    next_rx_status               = rx_status;
    if (bus.wr && hit(bus.addr, `RBFPC_ADDR_PIN_CTRL)) begin
      next_buffer_full_pin_control = bus.wdata & `RBFPC_CTRL_WMASK;
    end
    if (bus.wr && hit(bus.addr, `RBFPC_ADDR_IRQ_MASK)) begin
      next_rx_mask = bus.wdata[1:0];
    end
    // Write one clears; a new event in the same cycle wins
    if (bus.wr && hit(bus.addr, `RBFPC_ADDR_IRQ_STAT)) begin
      next_rx_status = next_rx_status & ~bus.wdata[1:0];
    end
    next_rx_status = next_rx_status | {rx1_loaded, rx0_loaded};
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      buffer_full_pin_control <= `RBFPC_CTRL_RST;
      rx_status               <= `RBFPC_STAT_RST;
      rx_mask                 <= `RBFPC_MASK_RST;
    end else begin
      buffer_full_pin_control <= next_buffer_full_pin_control;
      rx_status               <= next_rx_status;
      rx_mask                 <= next_rx_mask;
    end
  end

  // ----------------------------------------
  // Pin configuration decode
  // ----------------------------------------
  // pin zero fields
  assign cfg0 = '{en:       buffer_full_pin_control[`RBFPC_BIT_EN0],
                  irq_mode: buffer_full_pin_control[`RBFPC_BIT_MODE0],
                  level:    buffer_full_pin_control[`RBFPC_BIT_LVL0]};
  assign cfg1 = '{en:       buffer_full_pin_control[`RBFPC_BIT_EN1],
                  irq_mode: buffer_full_pin_control[`RBFPC_BIT_MODE1],
                  level:    buffer_full_pin_control[`RBFPC_BIT_LVL1]};

  // ----------------------------------------
  // Read path, data one cycle after the strobe
  // ----------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    if (bus.rd) begin
      if (hit(bus.addr, `RBFPC_ADDR_PIN_CTRL)) begin
        next_rdata = buffer_full_pin_control;
        next_rdata[`RBFPC_BIT_LVL0] = lvl_rd(cfg0.level, cfg0.irq_mode);
        next_rdata[`RBFPC_BIT_LVL1] = lvl_rd(cfg1.level, cfg1.irq_mode);
      end else if (hit(bus.addr, `RBFPC_ADDR_IRQ_STAT)) begin
        next_rdata = {6'h00, rx_status};
      end else if (hit(bus.addr, `RBFPC_ADDR_IRQ_MASK)) begin
        next_rdata = {6'h00, rx_mask};
      end
    end
  end

  // Read data stands one cycle only, zero otherwise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= `RBFPC_RDATA_RST;
    end else begin
      rdata <= next_rdata;
    end
  end

  // Level interrupt from unmasked sticky bits
  assign irq = |(rx_status & rx_mask);

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // zero pin function
  rbfpc_pin u_pin0 (
    .clk     (clk),
    .nrst    (nrst),
    .cfg     (cfg0),
    .rx_flag (rx_status[0]),
    .pin_o   (rx_full_pin_zero_o),
    .pin_oe  (rx_full_pin_zero_oe)
  );

  rbfpc_pin u_pin1 (
    .clk     (clk),
    .nrst    (nrst),
    .cfg     (cfg1),
    .rx_flag (rx_status[1]),
    .pin_o   (rx_full_pin_one_o),
    .pin_oe  (rx_full_pin_one_oe)
  );

endmodule

// ==== rbfpc_host.sv ====
// Host-side monitor that resolves the two buffer-full lines
`timescale 1ns/100ps
module rbfpc_host (
  // Clock
  input  wire logic clk,
  // Pins from the device
  input  wire logic p0_o,
  input  wire logic p0_oe,
  input  wire logic p1_o,
  input  wire logic p1_oe,
  // Resolved line levels
  output logic      lv0,
  output logic      lv1
);
  logic l0 = 1'b0;
  logic l1 = 1'b0;
  // Floating line never shows a stale level
  assign lv0 = p0_oe ? p0_o : ~l0;
  assign lv1 = p1_oe ? p1_o : ~l1;
  // Last level kept, so a float flips every cycle
  always_ff @(posedge clk) begin
    l0 <= lv0;
    l1 <= lv1;
  end
endmodule

// ==== rbfpc_top_props.sv ====
// Port checker for the buffer-full pin control block
`timescale 1ns/100ps
module rbfpc_props (
  // Clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // Register bus
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  // Events, pins, interrupt
  input wire logic       rx0_loaded,
  input wire logic       rx1_loaded,
  input wire logic       rx_full_pin_zero_o,
  input wire logic       rx_full_pin_zero_oe,
  input wire logic       rx_full_pin_one_o,
  input wire logic       rx_full_pin_one_oe,
  input wire logic       irq
);
  // ----------------------------------------
  // Control shadow
  // ----------------------------------------
  logic [7:0] ctl;
  logic [7:0] next_ctl;
  logic       wc;
  logic [7:0] rb;
  assign wc = wr && addr == 8'h0C;
  // State bits read as zero in interrupt mode
  assign rb = {2'b00, ctl[5] & ~ctl[1], ctl[4] & ~ctl[0], ctl[3:0]};
  // Shadow lets pin checks know the mode
  always_comb begin
    next_ctl = wc ? (wdata & 8'h3F) : ctl;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) ctl <= 8'h00;
    else ctl <= next_ctl;
  end
  sequence s_irq0;
    rx0_loaded && ctl[2] && ctl[0] && !wc;
  endsequence
  sequence s_irq1;
    rx1_loaded && ctl[3] && ctl[1] && !wc;
  endsequence
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_pin_zero_en: assert property (wc |=> ##1 rx_full_pin_zero_oe == $past(wdata[2], 2))
    else $error("pin zero enable wrong");
  a_pin_one_en: assert property (wc |=> ##1 rx_full_pin_one_oe == $past(wdata[3], 2))
    else $error("pin one enable wrong");
  a_gpo_zero: assert property (wc && wdata[2] && !wdata[0] |=> ##1
    rx_full_pin_zero_o == $past(wdata[4], 2)) else $error("pin zero level wrong");
  a_gpo_one: assert property (wc && wdata[3] && !wdata[1] |=> ##1
    rx_full_pin_one_o == $past(wdata[5], 2)) else $error("pin one level wrong");
  a_irq_zero_low: assert property (s_irq0 |=> ##1 !rx_full_pin_zero_o)
    else $error("pin zero not low");
  a_irq_one_low: assert property (s_irq1 |=> ##1 !rx_full_pin_one_o)
    else $error("pin one not low");
  a_read_ctl: assert property (rd && addr == 8'h0C |=> rdata == $past(rb))
    else $error("control readback wrong");
  a_irq_clear: assert property (wr && addr == 8'h2C && wdata == 8'h03 && !rx0_loaded
    && !rx1_loaded |=> !irq) else $error("irq after clear");
endmodule
bind rbfpc_top rbfpc_props u_props (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .rx0_loaded(rx0_loaded), .rx1_loaded(rx1_loaded),
  .rx_full_pin_zero_o(rx_full_pin_zero_o), .rx_full_pin_zero_oe(rx_full_pin_zero_oe),
  .rx_full_pin_one_o(rx_full_pin_one_o), .rx_full_pin_one_oe(rx_full_pin_one_oe), .irq(irq));

// ==== tb_rbfpc_top.sv ====
// Register-level testbench for the buffer-full pin control block
`timescale 1ns/100ps
module tb_rbfpc_top;
  logic       clk = 0;
  logic       nrst = 0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 0;
  logic       rd = 0;
  logic       rx0_loaded = 0;
  logic       rx1_loaded = 0;
  logic [7:0] rdata, v, e;
  logic       p0_o, p0_oe, p1_o, p1_oe, irq, lv0, lv1;
  int         num_errors = 0;
  int         n_tests = 0;
  int         cyc = 0;
  logic [7:0] vals [6] = '{8'hFF, 8'h3C, 8'h0C, 8'h00, 8'h34, 8'h39};
  rbfpc_top uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rx0_loaded(rx0_loaded), .rx1_loaded(rx1_loaded),
    .rx_full_pin_zero_o(p0_o), .rx_full_pin_zero_oe(p0_oe), .rx_full_pin_one_o(p1_o),
    .rx_full_pin_one_oe(p1_oe), .irq(irq));
  rbfpc_host host (.clk(clk), .p0_o(p0_o), .p0_oe(p0_oe), .p1_o(p1_o), .p1_oe(p1_oe),
    .lv0(lv0), .lv1(lv1));
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic close_out;
    if (num_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    n_tests++;
    if (g !== x) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, g, x);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, x);
  endtask
  // Pins lag a write by one more edge
  task automatic settle;
    @(posedge clk);
    @(negedge clk);
  endtask
  task automatic pulse(input logic b);
    @(posedge clk);
    if (b) rx1_loaded <= 1'b1;
    else rx0_loaded <= 1'b1;
    @(posedge clk);
    rx0_loaded <= 1'b0;
    rx1_loaded <= 1'b0;
    settle();
  endtask
  initial forever #2.5 clk = ~clk;
  // Hang guard, well above the run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk({6'h00, p0_oe, p1_oe}, 8'h00);
    wr_reg(8'h55, 8'hFF);
    rd_reg(8'h55, 8'h00);
    rd_reg(8'h2C, 8'h00);
    rd_reg(8'h0C, 8'h00);
    // Every enable and mode mix but disabled interrupt mode on pin one, readback masked in interrupt mode
    foreach (vals[i]) begin
      v = vals[i];
      e = v & 8'h3F;
      if (v[0]) e[4] = 1'b0;
      if (v[1]) e[5] = 1'b0;
      wr_reg(8'h0C, v);
      settle();
      chk({6'h00, p0_oe, p1_oe}, {6'h00, v[2], v[3]});
      chk({6'h00, lv0 | ~v[2], lv1 | ~v[3]},
        {6'h00, v[0] | v[4] | ~v[2], v[1] | v[5] | ~v[3]});
      rd_reg(8'h0C, e);
    end
    // Interrupt pins hold low until their flag is cleared
    wr_reg(8'h0C, 8'h3F);
    wr_reg(8'h2B, 8'h01);
    pulse(1'b0);
    chk({5'h00, lv0, lv1, irq}, 8'h03);
    pulse(1'b1);
    rd_reg(8'h2C, 8'h03);
    chk({5'h00, lv0, lv1, irq}, 8'h01);
    wr_reg(8'h2C, 8'h01);
    settle();
    chk({5'h00, lv0, lv1, irq}, 8'h04);
    wr_reg(8'h2B, 8'h03);
    settle();
    chk({5'h00, lv0, lv1, irq}, 8'h05);
    wr_reg(8'h2C, 8'h03);
    settle();
    chk({5'h00, lv0, lv1, irq}, 8'h06);
    // Output mode ignores receive events, status still sets
    wr_reg(8'h0C, 8'h3C);
    pulse(1'b0);
    chk({5'h00, lv0, lv1, irq}, 8'h07);
    close_out();
  end
endmodule
